// ### inc/lut_pkg.sv
package lut_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] upper_three_to_one_table_addr           = 8'h12;
  localparam logic [7:0] lower_three_to_one_table_addr           = 8'h13;
  localparam logic [7:0] lower_three_to_two_upper_out_table_addr = 8'h14;
  localparam logic [7:0] lower_three_to_two_lower_out_table_addr = 8'h15;
  localparam logic [7:0] table_reset                             = 8'h00;

  // ----------------------------------------
  // logic mode select codes
  // ----------------------------------------
  localparam logic [1:0] mode_off        = 2'h0;
  localparam logic [1:0] mode_two_to_one = 2'h1;
  localparam logic [1:0] mode_three_to_one = 2'h2;
  localparam logic [1:0] mode_three_to_two = 2'h3;

  // ----------------------------------------
  // pin positions
  // ----------------------------------------
  localparam int lower_in_lsb  = 0;
  localparam int lower_one_pin = 3;
  localparam int lower_two_pin = 4;
  localparam int upper_in_lsb  = 4;
  localparam int upper_one_pin = 7;

endpackage : lut_pkg

// ### logic/gpio_lookup_table_logic.sv
// How it works
// - in lower 3-to-1 mode pin 3 takes bit pins[2:0] of the lower 3-to-1 table.
// - in lower 3-to-2 mode pin 4 takes bit pins[2:0] of the 3-to-2 upper-out table.
// - in lower 3-to-2 mode pin 3 takes bit pins[2:0] of the 3-to-2 lower-out table.
// - a lower table only reaches the pins while the lower select holds its function.
// - in upper 3-to-1 mode pin 7 takes bit pins[6:4] of the upper table, bit 0 for 000.
// - the upper table applies only in upper 3-to-1 mode, bit 7 for pattern 111.
module gpio_lookup_table_logic (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] upper_three_to_one_table,
  input  wire logic [1:0] lower_half_logic_select,
  input  wire logic [1:0] upper_half_logic_select,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_out_valid
);

  // ----------------------------------------
  // table state
  // ----------------------------------------
  logic [7:0] lower_three_to_one_table;
  logic [7:0] lower_three_to_two_upper_out_table;
  logic [7:0] lower_three_to_two_lower_out_table;
  logic [2:0] table_hit;

  // ----------------------------------------
  // lookup wiring
  // ----------------------------------------
  logic [2:0] lower_pattern;
  logic [2:0] upper_pattern;
  logic       lower_single_on;
  logic       lower_double_on;
  logic       upper_single_on;
  logic       next_lower_one_level;
  logic       next_lower_two_level;
  logic       next_upper_one_level;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_out_valid;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one table bit per input pattern, bit n serves pattern n
  function automatic logic pick(input logic [7:0] table_bits, input logic [2:0] pattern);
    pick = table_bits[pattern];
  endfunction : pick

  // three adjacent pins form the lookup pattern
  // shared by both halves, only the lowest pin differs
  function automatic logic [2:0] three_bits(input logic [7:0] pins, input int lsb);
    three_bits = pins[lsb +: 3];
  endfunction : three_bits

  // one-hot hit on the mapped tables; zero means the address belongs elsewhere
  function automatic logic [2:0] decode_addr(input logic [7:0] addr);
    decode_addr = 3'h0;
    unique case (addr)
      lut_pkg::lower_three_to_one_table_addr:           decode_addr = 3'h1;
      lut_pkg::lower_three_to_two_upper_out_table_addr: decode_addr = 3'h2;
      lut_pkg::lower_three_to_two_lower_out_table_addr: decode_addr = 3'h4;
      default:                                          decode_addr = 3'h0;
    endcase
  endfunction : decode_addr

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // decoded once and shared, so writes and reads cannot disagree on the map
  assign table_hit = decode_addr(reg_addr);

  // ----------------------------------------
  // lower three-to-one table
  // ----------------------------------------
  // a write elsewhere leaves this table alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lower_three_to_one_table <= lut_pkg::table_reset;
    end else if (reg_write && table_hit[0]) begin
      lower_three_to_one_table <= reg_wdata;
    end
  end

  // ----------------------------------------
  // lower three-to-two upper-out table
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lower_three_to_two_upper_out_table <= lut_pkg::table_reset;
    end else if (reg_write && table_hit[1]) begin
      lower_three_to_two_upper_out_table <= reg_wdata;
    end
  end

  // ----------------------------------------
  // lower three-to-two lower-out table
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lower_three_to_two_lower_out_table <= lut_pkg::table_reset;
    end else if (reg_write && table_hit[2]) begin
      lower_three_to_two_lower_out_table <= reg_wdata;
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  // unmapped addresses read zero with reg_hit low, so the core can mux other blocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_hit <= 1'h0;
    end else begin
      reg_hit <= reg_read && (table_hit != 3'h0);
    end
  end

  // read data stands one cycle, then returns to zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (table_hit)
        3'h1:    reg_rdata <= lower_three_to_one_table;
        3'h2:    reg_rdata <= lower_three_to_two_upper_out_table;
        3'h4:    reg_rdata <= lower_three_to_two_lower_out_table;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign lower_pattern   = three_bits(pin_in, lut_pkg::lower_in_lsb);
  assign upper_pattern   = three_bits(pin_in, lut_pkg::upper_in_lsb);
  assign lower_single_on = lower_half_logic_select == lut_pkg::mode_three_to_one;
  assign lower_double_on = lower_half_logic_select == lut_pkg::mode_three_to_two;
  // upper select gate
  // the upper table sits outside; only the select decides if it reaches pin 7
  assign upper_single_on = upper_half_logic_select == lut_pkg::mode_three_to_one;

  // ----------------------------------------
  // table lookup
  // ----------------------------------------
  always_comb begin
    next_lower_one_level = 1'h0;
    if (lower_single_on) begin
      next_lower_one_level = pick(lower_three_to_one_table, lower_pattern);
    end else if (lower_double_on) begin
      next_lower_one_level = pick(lower_three_to_two_lower_out_table, lower_pattern);
    end
  end

  always_comb begin
    next_lower_two_level = 1'h0;
    if (lower_double_on) begin
      next_lower_two_level = pick(lower_three_to_two_upper_out_table, lower_pattern);
    end
  end

  always_comb begin
    next_upper_one_level = 1'h0;
    if (upper_single_on) begin
      next_upper_one_level = pick(upper_three_to_one_table, upper_pattern);
    end
  end

  // ----------------------------------------
  // output assembly
  // ----------------------------------------
  // pins this block does not own stay low and unflagged for the core's own drivers
  always_comb begin
    next_pin_out                         = 8'h00;
    next_pin_out[lut_pkg::lower_one_pin] = next_lower_one_level;
    next_pin_out[lut_pkg::lower_two_pin] = next_lower_two_level;
    next_pin_out[lut_pkg::upper_one_pin] = next_upper_one_level;
  end

  always_comb begin
    next_pin_out_valid                         = 8'h00;
    next_pin_out_valid[lut_pkg::lower_one_pin] = lower_single_on || lower_double_on;
    next_pin_out_valid[lut_pkg::lower_two_pin] = lower_double_on;
    next_pin_out_valid[lut_pkg::upper_one_pin] = upper_single_on;
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  // registered follow
  // one flop of latency keeps outputs glitch free at the cost of a cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out <= 8'h00;
    end else begin
      pin_out <= next_pin_out;
    end
  end

  // valid follows the select with the same latency as the level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out_valid <= 8'h00;
    end else begin
      pin_out_valid <= next_pin_out_valid;
    end
  end

endmodule : gpio_lookup_table_logic

// ### tb/lut_props.sv
module lut_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic       reg_hit,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] upper_three_to_one_table,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_out_valid,
  input wire logic [1:0] lower_half_logic_select,
  input wire logic [1:0] upper_half_logic_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       lo2, lo3, up2;
  logic [7:0] shadow_one, shadow_pair_hi, shadow_pair_lo;
  assign lo2 = lower_half_logic_select == lut_pkg::mode_three_to_one;
  assign lo3 = lower_half_logic_select == lut_pkg::mode_three_to_two;
  assign up2 = upper_half_logic_select == lut_pkg::mode_three_to_one;
  // shadow tables built from the writes seen on the ports
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_one     <= lut_pkg::table_reset;
      shadow_pair_hi <= lut_pkg::table_reset;
      shadow_pair_lo <= lut_pkg::table_reset;
    end else if (reg_write) begin
      if (reg_addr == lut_pkg::lower_three_to_one_table_addr) begin
        shadow_one <= reg_wdata;
      end
      if (reg_addr == lut_pkg::lower_three_to_two_upper_out_table_addr) begin
        shadow_pair_hi <= reg_wdata;
      end
      if (reg_addr == lut_pkg::lower_three_to_two_lower_out_table_addr) begin
        shadow_pair_lo <= reg_wdata;
      end
    end
  end
  a_lower_one_drive : assert property (lo2 |=> pin_out_valid[4:3] == 2'h1 &&
    pin_out[3] == $past(shadow_one[pin_in[2:0]])) else $error("pin 3 drive wrong");
  a_lower_two_upper : assert property (lo3 |=> pin_out_valid[4] &&
    pin_out[4] == $past(shadow_pair_hi[pin_in[2:0]])) else $error("pin 4 wrong");
  a_lower_two_lower : assert property (lo3 |=> pin_out_valid[3] &&
    pin_out[3] == $past(shadow_pair_lo[pin_in[2:0]])) else $error("pin 3 wrong");
  a_lower_off_quiet : assert property (!(lo2 || lo3) |=>
    {pin_out[4:3], pin_out_valid[4:3]} == 4'h0) else $error("lower pins driven");
  a_upper_pin_lookup : assert property (up2 |=> pin_out_valid[7] &&
    pin_out[7] == $past(upper_three_to_one_table[pin_in[6:4]])) else $error("pin 7 wrong");
  a_upper_off_quiet : assert property (!up2 |=> {pin_out[7], pin_out_valid[7]} == 2'h0)
    else $error("pin 7 driven");
  a_upper_follow_change : assert property (up2 ##1 (up2 && $changed(pin_in[6:4])) |=>
    pin_out[7] == $past(upper_three_to_one_table[pin_in[6:4]])) else $error("pin 7 stale");
  c_lower_two : cover property (lo3 ##1 pin_out[4]);
  c_upper_high : cover property (up2 ##1 pin_out[7]);
  c_read_hit : cover property (reg_hit);
endmodule : lut_props
bind gpio_lookup_table_logic lut_props chk (
  .clk                      (clk),
  .sys_rst                  (sys_rst),
  .reg_write                (reg_write),
  .reg_read                 (reg_read),
  .reg_hit                  (reg_hit),
  .reg_addr                 (reg_addr),
  .reg_wdata                (reg_wdata),
  .upper_three_to_one_table (upper_three_to_one_table),
  .pin_in                   (pin_in),
  .reg_rdata                (reg_rdata),
  .pin_out                  (pin_out),
  .pin_out_valid            (pin_out_valid),
  .lower_half_logic_select  (lower_half_logic_select),
  .upper_half_logic_select  (upper_half_logic_select)
);

// ### tb/gpio_lookup_table_logic_bench.sv
module gpio_lookup_table_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'h0, sys_rst = 1'h1, reg_write = 1'h0, reg_read = 1'h0, reg_hit;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, upper_three_to_one_table = 8'h00;
  logic [7:0] pin_in = 8'h00, reg_rdata, pin_out, pin_out_valid;
  logic [1:0] lower_half_logic_select = 2'h0, upper_half_logic_select = 2'h0;
  int         fail_count = 0, samples_checked = 0;
  always #5 clk = ~clk;
  gpio_lookup_table_logic uut (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .reg_write                (reg_write),
    .reg_read                 (reg_read),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .upper_three_to_one_table (upper_three_to_one_table),
    .lower_half_logic_select  (lower_half_logic_select),
    .upper_half_logic_select  (upper_half_logic_select),
    .pin_in                   (pin_in),
    .reg_rdata                (reg_rdata),
    .reg_hit                  (reg_hit),
    .pin_out                  (pin_out),
    .pin_out_valid            (pin_out_valid)
  );
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // an idle edge after each strobe keeps back-to-back calls from re-raising it at once
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1'h1;
    reg_addr  = a;
    reg_wdata = d;
    step;
    reg_write = 1'h0;
    step;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_read = 1'h1;
    reg_addr = a;
    step;
    reg_read = 1'h0;
    chk(reg_rdata, exp);
    chk({7'h00, reg_hit}, {7'h00, a inside {8'h13, 8'h14, 8'h15}});
    step;
    chk({reg_rdata[7:1], reg_rdata[0] | reg_hit}, 8'h00);
  endtask : rd
  // sweep every pattern on both halves; t4/t3/t7 are the expected tables
  task sweep(input logic [7:0] t4, t3, t7, v);
    for (int p = 0; p < 8; p++) begin
      pin_in = {1'h0, p[2:0], 1'h0, p[2:0]};
      step;
      chk(pin_out & 8'h98, {t7[p], 2'h0, t4[p], t3[p], 3'h0});
      chk(pin_out_valid & 8'h98, v);
      chk((pin_out | pin_out_valid) & 8'h67, 8'h00);
    end
  endtask : sweep
  task results;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (3) step;
    sys_rst = 1'h0;
    for (int a = 8'h12; a < 8'h17; a++) rd(a[7:0], 8'h00);
    $display("reset values done");
    wr(8'h13, 8'hA5); lower_half_logic_select = 2'h2;
    sweep(8'h00, 8'hA5, 8'h00, 8'h08);
    wr(8'h14, 8'h3C); wr(8'h15, 8'h96); lower_half_logic_select = 2'h3;
    upper_half_logic_select = 2'h2; upper_three_to_one_table = 8'h81;
    sweep(8'h3C, 8'h96, 8'h81, 8'h98);
    upper_three_to_one_table = 8'h5A;
    sweep(8'h3C, 8'h96, 8'h5A, 8'h98);
    $display("lookup done");
    lower_half_logic_select = 2'h0; upper_half_logic_select = 2'h1;
    sweep(8'h00, 8'h00, 8'h00, 8'h00);
    lower_half_logic_select = 2'h1; upper_half_logic_select = 2'h3;
    sweep(8'h00, 8'h00, 8'h00, 8'h00);
    wr(8'h12, 8'hFF);
    rd(8'h13, 8'hA5);
    rd(8'h14, 8'h3C);
    rd(8'h15, 8'h96);
    $display("idle modes done");
    sys_rst = 1'h1;
    step;
    step;
    sys_rst = 1'h0;
    chk(pin_out | pin_out_valid, 8'h00);
    for (int a = 8'h13; a < 8'h16; a++) begin
      rd(a[7:0], 8'h00);
    end
    lower_half_logic_select = 2'h2;
    upper_half_logic_select = 2'h2;
    sweep(8'h00, 8'h00, 8'h5A, 8'h88);
    $display("mid-run reset done");
    results;
  end
endmodule : gpio_lookup_table_logic_bench
